// ---- mef_pkg.sv ----
// package: register map and field layout of the missed-event error flag bank
package mef_pkg;
  localparam int          MEF_DMA_CH        = 64;
  localparam int          MEF_QCH           = 8;
  localparam int          MEF_HALF          = 32;
  localparam int          MEF_AW            = 12;
  localparam int          MEF_DW            = 32;
  localparam int          MEF_CTRL_W        = 4;
  localparam logic [11:0] MEF_FLAGS_LOW     = 12'h000;
  localparam logic [11:0] MEF_FLAGS_HIGH    = 12'h004;
  localparam logic [11:0] MEF_CLEAR_LOW     = 12'h008;
  localparam logic [11:0] MEF_CLEAR_HIGH    = 12'h00C;
  localparam logic [11:0] MEF_QFLAGS        = 12'h010;
  localparam logic [11:0] MEF_QCLEAR        = 12'h014;
  localparam logic [11:0] MEF_CTRL_FLAGS    = 12'h018;
  localparam logic [11:0] MEF_CTRL_CLEAR    = 12'h01C;
  localparam logic [11:0] MEF_IRQ_STATE     = 12'h020;
  localparam logic [31:0] MEF_ZERO          = 32'h00000000;
  localparam logic [63:0] MEF_FLAGS_RST     = 64'h0000000000000000;
  localparam logic [7:0]  MEF_QFLAGS_RST    = 8'h00;
  localparam logic [3:0]  MEF_CTRL_RST      = 4'h0;
endpackage

// ---- mef_bank.sv ----
// missed-event error flag bank with apb slave and error interrupt gating
`timescale 1ns/1ns
module mef_bank
  import mef_pkg::*;
#(
  parameter int DMA_CH = 64,
  parameter int QCH    = 8
)(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mef_pkg::MEF_AW-1:0]  paddr,
  input  wire logic [mef_pkg::MEF_DW-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [mef_pkg::MEF_DW-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [DMA_CH-1:0]           manual_trigger_set,
  input  wire logic [DMA_CH-1:0]           chain_trigger_flags,
  input  wire logic [DMA_CH-1:0]           external_trigger_flags,
  input  wire logic [DMA_CH-1:0]           manual_trigger_pend,
  input  wire logic [DMA_CH-1:0]           chain_trigger_pend,
  input  wire logic [DMA_CH-1:0]           external_trigger_pend,
  input  wire logic [DMA_CH-1:0]           dma_null_hit,
  input  wire logic [QCH-1:0]              quick_trigger,
  input  wire logic [QCH-1:0]              quick_trigger_pend,
  input  wire logic [QCH-1:0]              quick_null_hit,
  input  wire logic [mef_pkg::MEF_CTRL_W-1:0] ctrl_error_set,
  output logic                             error_irq,
  output logic [DMA_CH-1:0]                missed_flags,
  output logic [QCH-1:0]                   quick_flags
);
  import mef_pkg::*;

  logic [DMA_CH-1:0]     dma_q, dma_d, dma_set, dma_clr;
  logic [QCH-1:0]        quick_dma_channel_q, quick_dma_channel_d, quick_dma_channel_set, quick_dma_channel_clr;
  logic [MEF_CTRL_W-1:0] ctl_q, ctl_d, ctl_clr;
  logic                  irq_q, irq_d;
  logic                  any_q, any_d;
  logic [MEF_DW-1:0]     rd_q, rd_d;
  logic                  rdy_q, rdy_d, err_q, err_d;
  logic                  wr_acc, setup, known;
  logic [MEF_DW-1:0]     wmask, rdata;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && rdy_q;

  // byte strobes qualify every clear write
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : 8'h00;
    end
  end

  // per-channel set sources, all trigger types and the null hit ORed into one flag per channel
  genvar g;
  generate
    for (g = 0; g < DMA_CH; g++)
    begin : g_dma
      assign dma_set[g] = (manual_trigger_set[g] && manual_trigger_pend[g])
                        || (chain_trigger_flags[g] && chain_trigger_pend[g])
                        || (external_trigger_flags[g] && external_trigger_pend[g])
                        || dma_null_hit[g];
    end
    for (g = 0; g < QCH; g++)
    begin : g_quick_dma_channel
      assign quick_dma_channel_set[g] = (quick_trigger[g] && quick_trigger_pend[g])
                         || quick_null_hit[g];
    end
  endgenerate

  always_comb
  begin
    dma_clr  = '0;
    quick_dma_channel_clr = '0;
    ctl_clr  = '0;
    if (wr_acc && paddr == MEF_CLEAR_LOW)
    begin
      dma_clr[MEF_HALF-1:0] = wmask;
    end
    else if (wr_acc && paddr == MEF_CLEAR_HIGH)
    begin
      dma_clr[DMA_CH-1:MEF_HALF] = wmask[DMA_CH-MEF_HALF-1:0];
    end
    else if (wr_acc && paddr == MEF_QCLEAR)
    begin
      quick_dma_channel_clr = wmask[QCH-1:0];
    end
    else if (wr_acc && paddr == MEF_CTRL_CLEAR)
    begin
      ctl_clr = wmask[MEF_CTRL_W-1:0];
    end
  end

  // sticky flags: set beats clear, only software clears
  always_comb
  begin
    dma_d  = (dma_q & ~dma_clr) | dma_set;
    quick_dma_channel_d = (quick_dma_channel_q & ~quick_dma_channel_clr) | quick_dma_channel_set;
    ctl_d  = (ctl_q & ~ctl_clr) | ctrl_error_set;
    any_d  = (|dma_d) || (|quick_dma_channel_d) || (|ctl_d);
    // one pulse per rise from all-clear to any error
    irq_d  = !any_q && any_d;
  end

  // read mux, clear registers read zero
  always_comb
  begin
    known = 1'b1;
    rdata = MEF_ZERO;
    if (paddr == MEF_FLAGS_LOW)
    begin
      rdata = dma_q[MEF_HALF-1:0];
    end
    else if (paddr == MEF_FLAGS_HIGH)
    begin
      rdata = dma_q[DMA_CH-1:MEF_HALF];
    end
    else if (paddr == MEF_QFLAGS)
    begin
      rdata[QCH-1:0] = quick_dma_channel_q;
    end
    else if (paddr == MEF_CTRL_FLAGS)
    begin
      rdata[MEF_CTRL_W-1:0] = ctl_q;
    end
    else if (paddr == MEF_IRQ_STATE)
    begin
      rdata[0] = any_q;
    end
    else if (paddr == MEF_CLEAR_LOW || paddr == MEF_CLEAR_HIGH
             || paddr == MEF_QCLEAR || paddr == MEF_CTRL_CLEAR)
    begin
      rdata = MEF_ZERO;
    end
    else
    begin
      known = 1'b0;
    end
  end

  // no wait state: pready rises in the first access cycle
  always_comb
  begin
    rdy_d = setup;
    rd_d  = (setup && !pwrite) ? rdata : MEF_ZERO;
    err_d = setup && !known;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_q  <= MEF_FLAGS_RST;
      quick_dma_channel_q <= MEF_QFLAGS_RST;
      ctl_q  <= MEF_CTRL_RST;
      irq_q  <= 1'b0;
      any_q  <= 1'b0;
      rd_q   <= MEF_ZERO;
      rdy_q  <= 1'b0;
      err_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      dma_q  <= dma_d;
      quick_dma_channel_q <= quick_dma_channel_d;
      ctl_q  <= ctl_d;
      irq_q  <= irq_d;
      any_q  <= any_d;
      rd_q   <= rd_d;
      rdy_q  <= rdy_d;
      err_q  <= err_d;
    end
  end

  assign prdata       = rd_q;
  assign pready       = rdy_q;
  assign pslverr      = err_q;
  assign error_irq    = irq_q;
  assign missed_flags = dma_q;
  assign quick_flags  = quick_dma_channel_q;

  // helper masks for the checks below, one bit per channel
  logic [DMA_CH-1:0] chk_hold, chk_drop, chk_both;
  logic [QCH-1:0]    chk_qhold, chk_qdrop, chk_qmiss;
  assign chk_hold  = dma_q & ~dma_clr;
  assign chk_drop  = dma_clr & ~dma_set;
  assign chk_both  = dma_set & dma_clr;
  assign chk_qhold = quick_dma_channel_q & ~quick_dma_channel_clr;
  assign chk_qdrop = quick_dma_channel_clr & ~quick_dma_channel_set;
  assign chk_qmiss = quick_trigger & quick_trigger_pend;

  // sticky flags and software clears
  a_dma_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|chk_hold)
    |=> &(dma_q | ~$past(chk_hold)))
    else $error("dma flag dropped without clear");
  a_quick_dma_channel_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|chk_qhold)
    |=> &(quick_dma_channel_q | ~$past(chk_qhold)))
    else $error("quick flag dropped without clear");
  a_clear_low: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|chk_drop[MEF_HALF-1:0])
    |=> (dma_q[MEF_HALF-1:0] & $past(chk_drop[MEF_HALF-1:0])) == '0)
    else $error("low clear failed");
  a_clear_high: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|chk_drop[DMA_CH-1:MEF_HALF])
    |=> (dma_q[DMA_CH-1:MEF_HALF] & $past(chk_drop[DMA_CH-1:MEF_HALF])) == '0)
    else $error("high clear failed");
  a_qclear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|chk_qdrop)
    |=> (quick_dma_channel_q & $past(chk_qdrop)) == '0)
    else $error("quick clear failed");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|chk_both)
    |=> &(dma_q | ~$past(chk_both)))
    else $error("set lost to clear");
  a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en
    |=> $stable(dma_q) && $stable(quick_dma_channel_q) && $stable(ctl_q) && $stable(error_irq))
    else $error("state moved while clock enable low");

  // miss detection, each source on its own
  a_manual_miss: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|(manual_trigger_set & manual_trigger_pend))
    |=> &(dma_q | ~$past(manual_trigger_set & manual_trigger_pend)))
    else $error("manual miss not recorded");
  a_chain_miss: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|(chain_trigger_flags & chain_trigger_pend))
    |=> &(dma_q | ~$past(chain_trigger_flags & chain_trigger_pend)))
    else $error("chain miss not recorded");
  a_ext_miss: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|(external_trigger_flags & external_trigger_pend))
    |=> &(dma_q | ~$past(external_trigger_flags & external_trigger_pend)))
    else $error("external miss not recorded");
  a_dma_null: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|dma_null_hit)
    |=> &(dma_q | ~$past(dma_null_hit)))
    else $error("dma null hit not recorded");
  a_quick_set: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|chk_qmiss)
    |=> &(quick_dma_channel_q | ~$past(chk_qmiss)))
    else $error("quick miss not recorded");
  a_quick_null: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (|quick_null_hit)
    |=> &(quick_dma_channel_q | ~$past(quick_null_hit)))
    else $error("quick null hit not recorded");

  // interrupt gating across all error registers
  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    error_irq |-> $past(!any_q))
    else $error("interrupt raised while errors pending");
  a_irq_held: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && any_q |=> !error_irq)
    else $error("interrupt repeated before full clear");
  a_irq_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !any_q && (|ctrl_error_set) |=> error_irq)
    else $error("controller error gave no interrupt");
  a_irq_quick: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !any_q && (|quick_dma_channel_set) |=> error_irq)
    else $error("quick miss gave no interrupt");
  a_irq_dma: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !any_q && (|dma_set) |=> error_irq)
    else $error("dma miss gave no interrupt");

  // register reads
  a_qread_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && paddr == MEF_QFLAGS |-> prdata[MEF_DW-1:QCH] == '0)
    else $error("quick flag upper bits nonzero");
  a_clear_reads: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == MEF_CLEAR_LOW |-> prdata == MEF_ZERO)
    else $error("clear register returned data");
  a_qclear_reads: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && (paddr == MEF_CLEAR_HIGH || paddr == MEF_QCLEAR)
    |-> prdata == MEF_ZERO)
    else $error("clear register returned data");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && pready |=> !pready)
    else $error("ready held longer than one cycle");

  // main scenarios
  c_irq:      cover property (@(posedge pclk) error_irq);
  c_set_clr:  cover property (@(posedge pclk) clk_en && (|chk_both));
  c_qclear:   cover property (@(posedge pclk) clk_en && (|quick_dma_channel_clr));
  c_rearm:    cover property (@(posedge pclk) error_irq ##[1:50] error_irq);
  c_freeze:   cover property (@(posedge pclk) !clk_en && (|dma_null_hit));
endmodule // mef_bank

// ---- mef_trig_model.sv ----
// trigger source model: pulses triggers and holds pending state per type
`timescale 1ns/1ns
module mef_trig_model (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [1:0]       kind,
  input  wire logic [5:0]       chan,
  input  wire logic             fire,
  output logic      [3:0][63:0] trig,
  output logic      [3:0][63:0] pend
);
  logic [3:0][63:0] pend_d;
  logic [3:0][63:0] pend_q;
  always_comb
  begin
    trig = '0;
    pend_d = pend_q;
    trig[kind][chan] = fire;
    pend_d[kind][chan] = pend_q[kind][chan] | fire;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pend_q <= '0;
    else
      pend_q <= pend_d;
  assign pend = pend_q;
endmodule // mef_trig_model

// ---- mef_bank_test.sv ----
// self-checking bench of the missed-event error flag bank
`timescale 1ns/1ns
module mef_bank_test;
  import mef_pkg::*;
  logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic             pwrite = 1'b0, fire = 1'b0, clk_en = 1'b1, pready, pslverr, error_irq;
  logic [11:0]      paddr = '0;
  logic [31:0]      pwdata = '0, prdata, rd, m;
  logic [3:0]       pstrb = 4'hF, cset = '0, exp_c = '0;
  logic [1:0]       kind = '0;
  logic [5:0]       chan = '0, c, chn;
  logic [63:0]      nd = '0, missed_flags, exp_f = '0;
  logic [7:0]       nq = '0, quick_flags, exp_q = '0;
  logic [3:0][63:0] trig, pend;
  integer           seed = 86;
  int               errors = 0, checks = 0, irq_n = 0, irq_e = 0, n;
  always #50 pclk = ~pclk;
  always @(posedge pclk)
    if (error_irq === 1'b1)
      irq_n <= irq_n + 1;
  mef_bank u_mef_bank (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .manual_trigger_set(trig[0]),
    .chain_trigger_flags(trig[1]), .external_trigger_flags(trig[2]),
    .manual_trigger_pend(pend[0]), .chain_trigger_pend(pend[1]),
    .external_trigger_pend(pend[2]), .dma_null_hit(nd), .quick_trigger(trig[3][7:0]),
    .quick_trigger_pend(pend[3][7:0]), .quick_null_hit(nq), .ctrl_error_set(cset),
    .error_irq(error_irq), .missed_flags(missed_flags), .quick_flags(quick_flags));
  mef_trig_model u_mef_trig_model (.pclk(pclk), .presetn(presetn), .kind(kind),
    .chan(chan), .fire(fire), .trig(trig), .pend(pend));
  task automatic complete_run(input bit late);
    if (late)
      errors++;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st, input logic [63:0] hit);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    nd <= hit;
    do
    begin
      @(posedge pclk);
      nd <= '0;
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    chk(pslverr, a > MEF_IRQ_STATE, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      complete_run(1);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, '0, 4'h0, '0);
    chk(rd, e, "read");
  endtask
  // one event cycle: trigger through the model and null or controller pulses
  task automatic ev(input bit f, input int k, input logic [5:0] ch, input logic [63:0] d,
                    input logic [7:0] q, input logic [3:0] e);
    @(posedge pclk);
    fire <= f;
    kind <= 2'(k);
    chan <= ch;
    nd <= d;
    nq <= q;
    cset <= e;
    @(posedge pclk);
    fire <= 1'b0;
    nd <= '0;
    nq <= '0;
    cset <= '0;
  endtask
  // interrupt expected only when everything was clear before the new set
  function automatic void post(input logic [63:0] f, input logic [7:0] q, input logic [3:0] e);
    irq_e += int'({exp_f, exp_q, exp_c} == '0 && {f, q, e} != '0);
    exp_f |= f;
    exp_q |= q;
    exp_c |= e;
  endfunction
  task automatic settle();
    @(posedge pclk);
    @(negedge pclk);
    chk(missed_flags, exp_f, "dma flags");
    chk({56'h0, quick_flags}, {56'h0, exp_q}, "quick flags");
    chk(64'(irq_n), 64'(irq_e), "irq count");
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 10; a++)
      rdchk(12'(4 * a), '0);
    $display("reset test done");
    c = 6'($random(seed));
    for (int k = 0; k < 4; k++)
    begin
      chn = (k == 3) ? {3'b000, c[2:0]} : c;
      ev(1, k, chn, '0, '0, '0);
      settle();
      ev(1, k, chn, '0, '0, '0);
      post((k < 3) ? 64'h1 << c : '0, (k == 3) ? 8'h1 << chn : '0, '0);
      settle();
      ev(1, k, chn, '0, '0, '0);
      settle();
      if (k == 3)
        apb(1, MEF_QCLEAR, 32'hFFFFFF00 | 32'h1 << chn, 4'hF, '0);
      else
        apb(1, c[5] ? MEF_CLEAR_HIGH : MEF_CLEAR_LOW, 32'h1 << c[4:0], 4'hF, '0);
      exp_f = '0;
      exp_q = '0;
      settle();
    end
    $display("trigger test done");
    ev(0, 0, '0, '1, '1, 4'hF);
    post('1, '1, 4'hF);
    settle();
    rdchk(MEF_FLAGS_HIGH, '1);
    rdchk(MEF_QFLAGS, 32'h000000FF);
    for (int h = 0; h < 3; h++)
    begin
      m = $random(seed);
      apb(1, (h == 2) ? MEF_QCLEAR : (h == 1) ? MEF_CLEAR_HIGH : MEF_CLEAR_LOW, m, 4'hF, '0);
      exp_f &= ~((h == 2) ? 64'h0 : (h == 1) ? {m, 32'h0} : {32'h0, m});
      exp_q &= ~((h == 2) ? m[7:0] : 8'h0);
      settle();
    end
    rdchk(MEF_FLAGS_LOW, exp_f[31:0]);
    apb(1, MEF_CLEAR_LOW, '1, 4'h1, '0);
    exp_f &= ~64'hFF;
    settle();
    apb(1, MEF_CLEAR_HIGH, '1, 4'hF, 64'h1 << 63);
    exp_f = {32'h80000000, exp_f[31:0]};
    settle();
    apb(1, MEF_CLEAR_LOW, '1, 4'hF, '0);
    apb(1, MEF_CLEAR_HIGH, '1, 4'hF, '0);
    apb(1, MEF_QCLEAR, '1, 4'hF, '0);
    exp_f = '0;
    exp_q = '0;
    ev(0, 0, '0, 64'h1, '0, '0);
    post(64'h1, '0, '0);
    settle();
    apb(1, MEF_CTRL_CLEAR, '1, 4'hF, '0);
    apb(1, MEF_CLEAR_LOW, '1, 4'hF, '0);
    exp_f = '0;
    exp_c = '0;
    ev(0, 0, '0, '0, 8'h80, '0);
    post('0, 8'h80, '0);
    settle();
    $display("clear test done");
    // frozen clock enable: pulses are lost and every flag holds
    @(posedge pclk);
    clk_en <= 1'b0;
    ev(0, 0, '0, 64'h2, 8'h01, 4'h1);
    settle();
    @(posedge pclk);
    clk_en <= 1'b1;
    $display("freeze test done");
    complete_run(0);
  end
endmodule // mef_bank_test
